// file: core/e3r_pkg.sv
package e3r_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF      = 12'h000;
  localparam logic [11:0] STATUS_OFF    = 12'h004;
  localparam logic [11:0] INT_STAT_OFF  = 12'h008;
  localparam logic [11:0] INT_MASK_OFF  = 12'h00C;
  // control fields
  localparam int CTRL_EQ_BYPASS_BIT = 0;
  localparam int CTRL_FORCE_ACQ_BIT = 1;
  // status fields
  localparam int ST_LOL_BIT     = 0;
  localparam int ST_LOS_BIT     = 1;
  localparam int ST_ALOS_BIT    = 2;
  localparam int ST_DLOS_BIT    = 3;
  localparam int ST_FBAD_BIT    = 4;
  localparam int ST_THR_LSB     = 8;
  // interrupt fields
  localparam int IRQ_LOL_BIT    = 0;
  localparam int IRQ_LOS_BIT    = 1;
  localparam int IRQ_ACQTO_BIT  = 2;
  localparam int IRQ_W          = 3;
  // reset values
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [2:0]  INT_MASK_RST  = 3'h0;
  // alarm timing in recovered clock cycles
  localparam int MIN_ALARM_CYC  = 32;
  localparam int ZERO_RUN_BITS  = 160;
  localparam int DENS_WIN_BITS  = 32;
  localparam int DENS_MIN_ONES  = 8;
  localparam int PIPE_DEPTH     = 3;
  // frequency comparator: recovered edges per window of reference edges
  localparam int FREQ_WIN_EDGES = 1024;
  localparam int FREQ_TOL_PERMIL = 5;
  localparam int FREQ_TOL_EDGES = (FREQ_WIN_EDGES * FREQ_TOL_PERMIL) / 1000;
  // times and derived cycle counts at pclk
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int PHASE_HIT_US   = 2000;
  localparam int POWER_UP_US    = 20000;
  localparam int PHASE_HIT_CYC  = (PHASE_HIT_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int POWER_UP_CYC   = (POWER_UP_US * 1000) / (CLK_PERIOD_PS / 1000);
  // synchroniser input lanes
  localparam int SY_RCLK = 0;
  localparam int SY_REF  = 1;
  localparam int SY_POS  = 2;
  localparam int SY_NEG  = 3;
  localparam int SY_ALOS = 4;
  localparam int SY_P180 = 5;
  localparam int SY_ICT  = 6;
  localparam int SY_W    = 7;
endpackage

// file: core/e3r_top.sv
`timescale 1ns/10ps
module e3r_top #(
  parameter int PHASE_HIT_CYC = e3r_pkg::PHASE_HIT_CYC,
  parameter int POWER_UP_CYC  = e3r_pkg::POWER_UP_CYC,
  parameter int ZERO_RUN_BITS = e3r_pkg::ZERO_RUN_BITS,
  parameter int FREQ_WIN      = e3r_pkg::FREQ_WIN_EDGES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        recovered_clock_in,
  input  wire logic        reference_clock_in,
  input  wire logic        line_pos_pulse,
  input  wire logic        line_neg_pulse,
  input  wire logic        analog_loss_detect,
  input  wire logic        phase_inverted_detect,
  input  wire logic        incircuit_test_n,
  input  wire logic [1:0]  loss_threshold_select,
  output logic [1:0]       loss_threshold_level,
  output logic             equalizer_bypass,
  output logic             reacquire_force,
  output logic             recovered_clock_out,
  output logic             recovered_clock_oe,
  output logic             positive_rail_data,
  output logic             positive_rail_oe,
  output logic             negative_rail_data,
  output logic             negative_rail_oe,
  output logic             signal_loss_alarm,
  output logic             signal_loss_oe,
  output logic             lock_loss_alarm,
  output logic             lock_loss_oe
);

  logic [e3r_pkg::SY_W-1:0] sync1_q;
  logic [e3r_pkg::SY_W-1:0] sync2_q;
  logic [e3r_pkg::SY_W-1:0] prev_q;
  logic [1:0]  pipe_pos_q;
  logic [1:0]  pipe_neg_q;
  logic [7:0]  zero_run_q;
  logic [5:0]  win_cnt_q;
  logic [5:0]  ones_cnt_q;
  logic        dlos_q;
  logic [5:0]  los_hold_q;
  logic [5:0]  lol_hold_q;
  logic [11:0] ref_cnt_q;
  logic [11:0] rec_cnt_q;
  logic        freq_bad_q;
  logic        powered_q;
  logic [31:0] acq_tmr_q;
  logic        thr_taken_q;
  logic [1:0]  ctrl_q;
  logic [2:0]  int_stat_q;
  logic [2:0]  int_mask_q;
  logic        lol_prev_q;
  logic        los_prev_q;

  // edge detects read the second synchroniser stage and its delayed copy prev_q
  wire rclk_rise = sync2_q[e3r_pkg::SY_RCLK] & ~prev_q[e3r_pkg::SY_RCLK];
  wire ref_rise  = sync2_q[e3r_pkg::SY_REF]  & ~prev_q[e3r_pkg::SY_REF];
  wire bit_one   = sync2_q[e3r_pkg::SY_POS] | sync2_q[e3r_pkg::SY_NEG];
  wire alos      = sync2_q[e3r_pkg::SY_ALOS];
  wire phase180  = sync2_q[e3r_pkg::SY_P180];
  wire test_n    = sync2_q[e3r_pkg::SY_ICT];

  // apb decode
  wire        acc      = psel & penable & ~pready;
  wire        sel_ctrl = paddr == e3r_pkg::CTRL_OFF;
  wire        sel_stat = paddr == e3r_pkg::STATUS_OFF;
  wire        sel_ist  = paddr == e3r_pkg::INT_STAT_OFF;
  wire        sel_imsk = paddr == e3r_pkg::INT_MASK_OFF;
  wire        mapped   = sel_ctrl | sel_stat | sel_ist | sel_imsk;
  wire        wr_acc   = acc & pwrite & mapped;
  wire        rd_ist   = acc & ~pwrite & sel_ist;

  // alarm sources
  wire        dens_end  = win_cnt_q == 6'(e3r_pkg::DENS_WIN_BITS - 1);
  wire [5:0]  ones_next = ones_cnt_q + {5'h0, bit_one};
  wire        los_src   = alos | dlos_q;
  wire        lol_src   = freq_bad_q | phase180 | ~powered_q | ctrl_q[e3r_pkg::CTRL_FORCE_ACQ_BIT];
  wire        acq_to    = lock_loss_alarm & (acq_tmr_q == 32'(PHASE_HIT_CYC - 1));
  wire [11:0] freq_diff = (rec_cnt_q > 12'(FREQ_WIN)) ? rec_cnt_q - 12'(FREQ_WIN)
                                                      : 12'(FREQ_WIN) - rec_cnt_q;
  wire        freq_out  = freq_diff > 12'(e3r_pkg::FREQ_TOL_EDGES);
  wire [2:0]  int_evt   = {acq_to, los_src & ~los_prev_q, lol_src & ~lol_prev_q};

  wire [31:0] status_word = {16'h0000, 6'h00, loss_threshold_level, 3'h0,
                             freq_bad_q, dlos_q, alos, signal_loss_alarm, lock_loss_alarm};
  wire [31:0] rd_word = sel_ctrl ? 32'(ctrl_q) :
                        sel_stat ? status_word :
                        sel_ist  ? 32'(int_stat_q) :
                        sel_imsk ? 32'(int_mask_q) : 32'h0000_0000;

  // two-flop synchronisers for the seven link-side pin inputs; loss_threshold_select is sampled directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else if (clk_en) begin
      sync1_q <= {incircuit_test_n, phase_inverted_detect, analog_loss_detect,
                  line_neg_pulse, line_pos_pulse, reference_clock_in, recovered_clock_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // three-stage retiming on recovered rising edges; recovery never stops for los
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_pos_q         <= '0;
      pipe_neg_q         <= '0;
      positive_rail_data <= 1'b0;
      negative_rail_data <= 1'b0;
    end else if (clk_en && rclk_rise) begin
      pipe_pos_q         <= {pipe_pos_q[0], sync2_q[e3r_pkg::SY_POS]};
      pipe_neg_q         <= {pipe_neg_q[0], sync2_q[e3r_pkg::SY_NEG]};
      // both pulses at once is treated as a zero
      positive_rail_data <= pipe_pos_q[1] & ~pipe_neg_q[1];
      negative_rail_data <= pipe_neg_q[1] & ~pipe_pos_q[1];
    end
  end

  // recovered clock mirror, aligned with the rail updates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovered_clock_out <= 1'b0;
    end else if (clk_en) begin
      recovered_clock_out <= sync2_q[e3r_pkg::SY_RCLK];
    end
  end

  // digital ones-density detector, block windows of 32 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_run_q <= '0;
      win_cnt_q  <= '0;
      ones_cnt_q <= '0;
      dlos_q     <= 1'b0;
    end else if (clk_en && rclk_rise) begin
      if (!dlos_q) begin
        zero_run_q <= bit_one ? 8'h00 : zero_run_q + 8'h01;
        if (!bit_one && zero_run_q == 8'(ZERO_RUN_BITS - 1)) begin
          dlos_q     <= 1'b1;
          win_cnt_q  <= '0;
          ones_cnt_q <= '0;
        end
      end else begin
        win_cnt_q  <= dens_end ? 6'h00 : win_cnt_q + 6'h01;
        ones_cnt_q <= dens_end ? 6'h00 : ones_next;
        if (dens_end && ones_next >= 6'(e3r_pkg::DENS_MIN_ONES)) begin
          dlos_q     <= 1'b0;
          zero_run_q <= '0;
        end
      end
    end
  end

  // signal loss alarm with minimum width counted in recovered cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signal_loss_alarm <= 1'b0;
      los_hold_q        <= '0;
    end else if (clk_en) begin
      if (los_src && !signal_loss_alarm) begin
        signal_loss_alarm <= 1'b1;
        los_hold_q        <= '0;
      end else if (signal_loss_alarm && rclk_rise) begin
        if (los_hold_q != 6'(e3r_pkg::MIN_ALARM_CYC)) begin
          los_hold_q <= los_hold_q + 6'h01;
        end else if (!los_src) begin
          signal_loss_alarm <= 1'b0;
        end
      end
    end
  end

  // frequency comparator: recovered edges per window of reference edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q  <= '0;
      rec_cnt_q  <= '0;
      freq_bad_q <= 1'b0;
      powered_q  <= 1'b0;
    end else if (clk_en) begin
      if (ref_rise && ref_cnt_q == 12'(FREQ_WIN - 1)) begin
        ref_cnt_q  <= '0;
        rec_cnt_q  <= '0;
        freq_bad_q <= freq_out;
        powered_q  <= 1'b1; // first verdict ends the power-up alarm
      end else begin
        if (ref_rise) begin
          ref_cnt_q <= ref_cnt_q + 12'h001;
        end
        // saturate so a runaway clock still reads as out of range
        if (rclk_rise && rec_cnt_q != 12'hFFF) begin
          rec_cnt_q <= rec_cnt_q + 12'h001;
        end
      end
    end
  end

  // lock loss alarm: held until every lol_src cause clears and at least 32 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_loss_alarm <= 1'b0;
      lol_hold_q      <= '0;
    end else if (clk_en) begin
      if (lol_src && !lock_loss_alarm) begin
        lock_loss_alarm <= 1'b1;
        lol_hold_q      <= '0;
      end else if (lock_loss_alarm && rclk_rise) begin
        if (lol_hold_q != 6'(e3r_pkg::MIN_ALARM_CYC)) begin
          lol_hold_q <= lol_hold_q + 6'h01;
        end else if (!lol_src) begin
          lock_loss_alarm <= 1'b0;
        end
      end
    end
  end

  // reacquisition drive and its watchdog; a stuck lock retries every 2 ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reacquire_force <= 1'b0;
      acq_tmr_q       <= '0;
    end else if (clk_en) begin
      reacquire_force <= freq_bad_q | phase180 | acq_to;
      if (!lock_loss_alarm || acq_to) begin
        acq_tmr_q <= '0;
      end else begin
        acq_tmr_q <= acq_tmr_q + 32'h0000_0001;
      end
    end
  end

  // threshold strap caught once after reset release, then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_taken_q          <= 1'b0;
      loss_threshold_level <= 2'h0;
    end else if (clk_en && !thr_taken_q) begin
      thr_taken_q          <= 1'b1;
      loss_threshold_level <= loss_threshold_select;
    end
  end

  // pin drivers float while the test pin is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovered_clock_oe <= 1'b0;
      positive_rail_oe   <= 1'b0;
      negative_rail_oe   <= 1'b0;
      signal_loss_oe     <= 1'b0;
      lock_loss_oe       <= 1'b0;
    end else if (clk_en) begin
      recovered_clock_oe <= test_n;
      positive_rail_oe   <= test_n;
      negative_rail_oe   <= test_n;
      signal_loss_oe     <= test_n;
      lock_loss_oe       <= test_n;
    end
  end

  // apb slave, one wait state; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      ctrl_q     <= e3r_pkg::CTRL_RST;
      int_mask_q <= e3r_pkg::INT_MASK_RST;
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc && !pwrite) begin
        prdata <= rd_word;
      end
      if (wr_acc && sel_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (wr_acc && sel_imsk) begin
        int_mask_q <= pwdata[2:0];
      end
    end
  end

  // sticky events, cleared by reading; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
      lol_prev_q <= 1'b0;
      los_prev_q <= 1'b0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      lol_prev_q <= lol_src;
      los_prev_q <= los_src;
      int_stat_q <= (rd_ist ? 3'h0 : int_stat_q) | int_evt;
      irq        <= |(int_stat_q & int_mask_q);
    end
  end

  assign equalizer_bypass = ctrl_q[e3r_pkg::CTRL_EQ_BYPASS_BIT];

endmodule

// file: bench/e3r_checker.sv
`timescale 1ns/10ps
module e3r_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pslverr,
  input wire logic incircuit_test_n,
  input wire logic analog_loss_detect,
  input wire logic phase_inverted_detect,
  input wire logic reacquire_force,
  input wire logic recovered_clock_out,
  input wire logic recovered_clock_oe,
  input wire logic positive_rail_data,
  input wire logic positive_rail_oe,
  input wire logic negative_rail_data,
  input wire logic negative_rail_oe,
  input wire logic signal_loss_alarm,
  input wire logic signal_loss_oe,
  input wire logic lock_loss_alarm,
  input wire logic lock_loss_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        rck_q;
  logic [15:0] los_n_q;
  logic [15:0] lol_n_q;
  wire         rck_rise = recovered_clock_out && !rck_q;
  wire         any_oe = recovered_clock_oe | positive_rail_oe | negative_rail_oe
                        | signal_loss_oe | lock_loss_oe;
  // recovered edges while an alarm stands; one edge of slack for sampling skew
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rck_q   <= 1'b0;
      los_n_q <= '0;
      lol_n_q <= '0;
    end else begin
      rck_q   <= recovered_clock_out;
      los_n_q <= signal_loss_alarm ? los_n_q + {15'h0, rck_rise} : '0;
      lol_n_q <= lock_loss_alarm ? lol_n_q + {15'h0, rck_rise} : '0;
    end
  end
  float_pins_a: assert property (!incircuit_test_n [*5] |-> !any_oe)
    else $error("outputs driven in test mode");
  analog_loss_a: assert property (analog_loss_detect [*5] |-> signal_loss_alarm)
    else $error("analog loss not flagged");
  los_width_a: assert property ($fell(signal_loss_alarm) |-> los_n_q >= 16'h001f)
    else $error("signal alarm too short");
  lol_width_a: assert property ($fell(lock_loss_alarm) |-> lol_n_q >= 16'h001f)
    else $error("lock alarm too short");
  rail_excl_a: assert property (!(positive_rail_data && negative_rail_data))
    else $error("both rails high");
  rail_edge_a: assert property (($changed(positive_rail_data) || $changed(negative_rail_data))
    |-> ##[0:1] recovered_clock_out)
    else $error("rails moved away from rising clock");
  phase_lock_a: assert property (phase_inverted_detect [*5] |-> lock_loss_alarm)
    else $error("phase inversion not flagged");
  phase_reacq_a: assert property (phase_inverted_detect [*5] |-> reacquire_force)
    else $error("no reacquisition forced");
  cover property ($rose(signal_loss_alarm));
  cover property ($fell(lock_loss_alarm));
  cover property (pslverr);
endmodule
bind e3r_top e3r_checker chk_i (
  .pclk(pclk), .presetn(presetn), .pslverr(pslverr), .incircuit_test_n(incircuit_test_n),
  .analog_loss_detect(analog_loss_detect), .phase_inverted_detect(phase_inverted_detect),
  .reacquire_force(reacquire_force), .recovered_clock_out(recovered_clock_out),
  .recovered_clock_oe(recovered_clock_oe), .positive_rail_data(positive_rail_data),
  .positive_rail_oe(positive_rail_oe), .negative_rail_data(negative_rail_data),
  .negative_rail_oe(negative_rail_oe), .signal_loss_alarm(signal_loss_alarm),
  .signal_loss_oe(signal_loss_oe), .lock_loss_alarm(lock_loss_alarm),
  .lock_loss_oe(lock_loss_oe)
);

// file: bench/e3r_framer_model.sv
`timescale 1ns/10ps
module e3r_framer_model (
  input  wire logic clk_pin,
  input  wire logic clk_oe,
  input  wire logic pos_pin,
  input  wire logic neg_pin,
  input  wire logic rails_oe,
  output logic      rx_pos,
  output logic      rx_neg,
  output int        rx_cnt
);
  initial begin
    rx_pos = 1'b0;
    rx_neg = 1'b0;
    rx_cnt = 0;
  end
  // falling edge is mid-bit; floating pins give no symbol, loss alarm is never read
  always @(negedge clk_pin) begin
    if (clk_oe && rails_oe) begin
      rx_pos <= pos_pin;
      rx_neg <= neg_pin;
      rx_cnt <= rx_cnt + 1;
    end
  end
endmodule

// file: bench/tb_e3_receiver_alarm_output_logic.sv
`timescale 1ns/10ps
module tb_e3_receiver_alarm_output_logic;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, irq, er, rx_pos, rx_neg, incircuit_test_n = 1'b1;
  logic        recovered_clock_in = 1'b0, reference_clock_in = 1'b0, line_pos_pulse = 1'b0;
  logic        line_neg_pulse = 1'b0, analog_loss_detect = 1'b0, phase_inverted_detect = 1'b0;
  logic [1:0]  loss_threshold_select = 2'h2, loss_threshold_level;
  logic        equalizer_bypass, reacquire_force, recovered_clock_out, recovered_clock_oe;
  logic        positive_rail_data, positive_rail_oe, negative_rail_data, negative_rail_oe;
  logic        signal_loss_alarm, signal_loss_oe, lock_loss_alarm, lock_loss_oe;
  int          rx_cnt, rises = 0, fails = 0, checks = 0;
  real         ref_half = 24.0;
  // short acquisition window keeps frequency verdicts quick
  e3r_top #(.PHASE_HIT_CYC(200), .FREQ_WIN(64)) uut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .recovered_clock_in(recovered_clock_in),
    .reference_clock_in(reference_clock_in), .line_pos_pulse(line_pos_pulse),
    .line_neg_pulse(line_neg_pulse), .analog_loss_detect(analog_loss_detect),
    .phase_inverted_detect(phase_inverted_detect), .incircuit_test_n(incircuit_test_n),
    .loss_threshold_select(loss_threshold_select), .loss_threshold_level(loss_threshold_level),
    .equalizer_bypass(equalizer_bypass), .reacquire_force(reacquire_force),
    .recovered_clock_out(recovered_clock_out), .recovered_clock_oe(recovered_clock_oe),
    .positive_rail_data(positive_rail_data), .positive_rail_oe(positive_rail_oe),
    .negative_rail_data(negative_rail_data), .negative_rail_oe(negative_rail_oe),
    .signal_loss_alarm(signal_loss_alarm), .signal_loss_oe(signal_loss_oe),
    .lock_loss_alarm(lock_loss_alarm), .lock_loss_oe(lock_loss_oe)
  );
  e3r_framer_model framer (
    .clk_pin(recovered_clock_out), .clk_oe(recovered_clock_oe), .pos_pin(positive_rail_data),
    .neg_pin(negative_rail_data), .rails_oe(positive_rail_oe & negative_rail_oe),
    .rx_pos(rx_pos), .rx_neg(rx_neg), .rx_cnt(rx_cnt)
  );
  // clocks; odd offsets keep link edges off the bus clock edges
  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    #1.3;
    forever #24 recovered_clock_in = ~recovered_clock_in;
  end
  initial begin
    #7.1;
    forever #(ref_half) reference_clock_in = ~reference_clock_in;
  end
  always @(posedge recovered_clock_in) rises++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one apb transfer; idle edge first so back-to-back calls never collide
  // waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one line bit per recovered period, changed mid-period; k=0 sends zeros
  task automatic bits(input int n, input int k);
    for (int i = 0; i < n; i++) begin
      @(negedge recovered_clock_in);
      @(posedge pclk);
      line_pos_pulse <= (k > 0) && (i % k == 0);
      line_neg_pulse <= 1'b0;
    end
  endtask
  task automatic sym(input logic p, input logic n, input logic ep, input logic en);
    int r0;
    int c0;
    @(negedge recovered_clock_in);
    @(posedge pclk);
    line_pos_pulse <= p;
    line_neg_pulse <= n;
    r0 = rises;
    bits(1, 0);
    while (rises < r0 + 3) @(posedge pclk);
    c0 = rx_cnt;
    while (rx_cnt == c0) @(posedge pclk);
    chk(rx_pos, ep);
    chk(rx_neg, en);
  endtask
  task automatic t_regs;
    apb(1'b1, e3r_pkg::CTRL_OFF, 32'h0000_0001);
    apb(1'b0, e3r_pkg::CTRL_OFF, 32'h0000_0000);
    chk(rd[1:0], 2'h1);
    chk(equalizer_bypass, 1'b1);
    apb(1'b0, e3r_pkg::STATUS_OFF, 32'h0000_0000);
    chk(rd[e3r_pkg::ST_LOL_BIT], 1'b1);
    chk(rd[e3r_pkg::ST_THR_LSB +: 2], 2'h2);
    chk(loss_threshold_level, 2'h2);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_float;
    incircuit_test_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({recovered_clock_oe, positive_rail_oe, negative_rail_oe, signal_loss_oe,
         lock_loss_oe}, 5'h00);
    incircuit_test_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({recovered_clock_oe, positive_rail_oe, negative_rail_oe, signal_loss_oe,
         lock_loss_oe}, 5'h1f);
  endtask
  // density pattern: a one every 5 bits (6 or 7 per 32) must hold the alarm, one every 4 bits (8 per 32) must drop it
  task automatic t_stream;
    bits(64, 1);
    bits(128, 0);
    chk(signal_loss_alarm, 1'b0);
    bits(64, 0);
    chk(signal_loss_alarm, 1'b1);
    sym(1'b1, 1'b0, 1'b1, 1'b0);
    sym(1'b0, 1'b1, 1'b0, 1'b1);
    sym(1'b1, 1'b1, 1'b0, 1'b0);
    bits(32, 0);
    bits(64, 5);
    chk(signal_loss_alarm, 1'b1);
    bits(80, 4);
    chk(signal_loss_alarm, 1'b0);
  endtask
  task automatic t_analog;
    line_pos_pulse <= 1'b1;
    analog_loss_detect <= 1'b1;
    repeat (6) @(posedge pclk);
    analog_loss_detect <= 1'b0;
    chk(signal_loss_alarm, 1'b1);
    repeat (240) @(posedge pclk);
    chk(signal_loss_alarm, 1'b1);
    repeat (300) @(posedge pclk);
    chk(signal_loss_alarm, 1'b0);
  endtask
  task automatic t_lock;
    chk(lock_loss_alarm, 1'b0);
    apb(1'b1, e3r_pkg::INT_MASK_OFF, 32'h0000_0001);
    apb(1'b0, e3r_pkg::INT_STAT_OFF, 32'h0000_0000);
    for (int m = 1; m >= 0; m--) begin
      phase_inverted_detect <= 1'b1;
      repeat (8) @(posedge pclk);
      phase_inverted_detect <= 1'b0;
      chk(reacquire_force, 1'b1);
      chk(lock_loss_alarm, 1'b1);
      chk(irq, m[0]);
      apb(1'b0, e3r_pkg::INT_STAT_OFF, 32'h0000_0000);
      chk(rd[e3r_pkg::IRQ_LOL_BIT], 1'b1);
      // the watchdog fired during the first held alarm, seen at the second read
      chk(rd[e3r_pkg::IRQ_ACQTO_BIT], !m[0]);
      repeat (200) @(posedge pclk);
      chk({irq, lock_loss_alarm}, 2'h1);
      repeat (1400) @(posedge pclk);
      chk(lock_loss_alarm, 1'b0);
      apb(1'b1, e3r_pkg::INT_MASK_OFF, 32'h0000_0000);
    end
  endtask
  // a 56 ns reference is far outside the comparator band
  task automatic t_freq;
    ref_half = 28.0;
    repeat (2800) @(posedge pclk);
    chk({lock_loss_alarm, reacquire_force}, 2'h3);
    ref_half = 24.0;
    repeat (2800) @(posedge pclk);
    chk(lock_loss_alarm, 1'b0);
    // software force through the control word, then released
    apb(1'b1, e3r_pkg::CTRL_OFF, 32'h0000_0002);
    apb(1'b0, e3r_pkg::STATUS_OFF, 32'h0000_0000);
    chk(rd[e3r_pkg::ST_LOL_BIT], 1'b1);
    apb(1'b1, e3r_pkg::CTRL_OFF, 32'h0000_0000);
    repeat (600) @(posedge pclk);
    chk(lock_loss_alarm, 1'b0);
  endtask
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_float();
    t_stream();
    t_analog();
    t_lock();
    t_freq();
    tally_and_finish();
  end
endmodule
